// file: logic/clk_ctrl_pkg.sv
package clk_ctrl_pkg;

  // register byte offsets on the 32-bit bus
  localparam logic [31:0] RUN_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] SPEED_OFS    = 32'h0000_0004;
  localparam logic [31:0] SYSSEL_OFS   = 32'h0000_0008;
  localparam logic [31:0] PINMODE_OFS  = 32'h0000_000C;

  // field positions
  localparam int RUN_MAIN_HALT_BIT = 7;
  localparam int RUN_SUB_HALT_BIT  = 6;
  localparam int RUN_FAST_HALT_BIT = 0;
  localparam int SPD_GATE_BIT      = 7;
  localparam int SPD_TIMER_SEL_BIT = 4;
  localparam int SEL_CPU_STAT_BIT  = 7;
  localparam int SEL_CPU_SRC_BIT   = 6;
  localparam int SEL_MAIN_STAT_BIT = 5;
  localparam int SEL_MAIN_SRC_BIT  = 4;
  localparam int PIN_EXT_MAIN_BIT  = 7;
  localparam int PIN_MAIN_SEL_BIT  = 6;
  localparam int PIN_EXT_SUB_BIT   = 5;
  localparam int PIN_SUB_SEL_BIT   = 4;

  // writable bits of the run control, speed and pin mode registers
  localparam logic [7:0] RUN_CTRL_MASK = 8'hC1;
  localparam logic [7:0] SPEED_MASK    = 8'h90;
  localparam logic [7:0] PINMODE_MASK  = 8'hF0;

  // values after reset
  localparam logic [7:0] RUN_CTRL_RST = 8'hC0;
  localparam logic [7:0] SPEED_RST    = 8'h00;
  localparam logic [7:0] PINMODE_RST  = 8'h00;
  localparam logic       SRC_SEL_RST  = 1'b0;

  // cycles a new source must stay available before the switch lands
  localparam logic [2:0] SETTLE_CYCLES = 3'h4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    PIN_PORT = 2'b00,
    PIN_OSC  = 2'b01,
    PIN_EXT  = 2'b11
  } pin_mode_t;

  typedef enum logic [1:0] {
    SW_STEADY = 2'b00,
    SW_WAIT   = 2'b01,
    SW_SETTLE = 2'b10
  } switch_state_t;

  // pin pair mode from its external-clock and oscillator-select bits
  function automatic pin_mode_t pin_mode(input logic ext, input logic sel);
    case ({ext, sel})
      2'b01:   pin_mode = PIN_OSC;
      2'b11:   pin_mode = PIN_EXT;
      default: pin_mode = PIN_PORT;
    endcase
  endfunction

  // true for any mapped register address
  function automatic logic reg_hit(input logic [31:0] addr);
    reg_hit = (addr == RUN_CTRL_OFS) || (addr == SPEED_OFS) ||
              (addr == SYSSEL_OFS) || (addr == PINMODE_OFS);
  endfunction

endpackage

// file: logic/clk_ctrl_if.sv
`timescale 1ns/1ns
// register access between bus slave and register file
interface reg_access_if;
  logic        wr_pulse;
  logic [31:0] wr_addr;
  logic [7:0]  wr_data;
  logic [31:0] rd_addr;
  logic [7:0]  rd_data;
  logic        rd_hit;
  modport slave (output wr_pulse, wr_addr, wr_data, rd_addr,
                 input  rd_data, rd_hit);
  modport regs  (input  wr_pulse, wr_addr, wr_data, rd_addr,
                 output rd_data, rd_hit);
endinterface

// subsystem clock gating controls
interface gate_ctrl_if;
  logic cpu_on_sub;
  logic standby;
  logic gate_enable;
  logic timer_lowspeed;
  logic sub_periph_en;
  logic timer_from_sub;
  logic timer_from_lowspeed;
  modport ctrl (output cpu_on_sub, standby, gate_enable, timer_lowspeed,
                input  sub_periph_en, timer_from_sub, timer_from_lowspeed);
  modport gate (input  cpu_on_sub, standby, gate_enable, timer_lowspeed,
                output sub_periph_en, timer_from_sub, timer_from_lowspeed);
endinterface

// file: logic/axi_lite_port.sv
`timescale 1ns/1ns
module axi_lite_port
  import clk_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write channels
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // read channels
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // register side
  reg_access_if.slave      regs
);
  import clk_ctrl_pkg::*;

  logic        aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [31:0] aw_addr_r, aw_addr_nxt;
  logic [7:0]  w_data_r, w_data_nxt;
  logic        w_strb_r, w_strb_nxt;
  logic        awready_r, awready_nxt, wready_r, wready_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic        arready_r, arready_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        commit;

  // write commits once both address and data are held
  assign commit        = aw_held_r && w_held_r;
  assign regs.wr_pulse = commit && w_strb_r;
  assign regs.wr_addr  = aw_addr_r;
  assign regs.wr_data  = w_data_r;
  assign regs.rd_addr  = araddr;

  // channel bookkeeping
  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt  = w_held_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r && !bready;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r && !rready;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      w_data_nxt = wdata[7:0];
      w_strb_nxt = wstrb[0];
    end
    if (commit) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = reg_hit(aw_addr_r) ? RESP_OKAY : RESP_DECERR;
    end
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = regs.rd_hit ? RESP_OKAY : RESP_DECERR;
      rdata_nxt  = {24'h00_0000, regs.rd_data};
    end
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt  = !w_held_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      w_held_r  <= 1'b0;
      w_data_r  <= 8'h00;
      w_strb_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r  <= w_held_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      arready_r <= arready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign awready = awready_r;
  assign wready  = wready_r;
  assign arready = arready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;

endmodule // axi_lite_port

// file: logic/sub_clock_gate.sv
`timescale 1ns/1ns
module sub_clock_gate (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // gating controls
  gate_ctrl_if.gate ctl
);

  logic periph_en_r, periph_en_nxt;
  logic from_sub_r, from_sub_nxt;
  logic from_low_r, from_low_nxt;

  // low-power gating and timer clock choice
  always_comb begin
    periph_en_nxt = !(ctl.gate_enable && ctl.cpu_on_sub
                      && ctl.standby);
    from_sub_nxt  = !ctl.timer_lowspeed;
    from_low_nxt  = ctl.timer_lowspeed;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_en_r <= 1'b1;
      from_sub_r  <= 1'b1;
      from_low_r  <= 1'b0;
    end else begin
      periph_en_r <= periph_en_nxt;
      from_sub_r  <= from_sub_nxt;
      from_low_r  <= from_low_nxt;
    end
  end

  assign ctl.sub_periph_en       = periph_en_r;
  assign ctl.timer_from_sub      = from_sub_r;
  assign ctl.timer_from_lowspeed = from_low_r;

endmodule // sub_clock_gate

// file: logic/system_clock_gating_select.sv
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
// Operation
// - main halt bit 0 runs main oscillator or accepts clock, 1 halts
// - sub halt bit 0 keeps sub oscillator or clock valid, 1 stops
// - fast internal halt bit 0 runs that oscillator, 1 stops it
// - gate bit 1: sub clock withheld from peripherals in standby on sub
// - gate bit 0: sub clock keeps feeding peripherals in standby
// - timer select 0 takes sub clock, 1 the low-speed internal clock
// - cpu source bit 0 picks main clock, 1 picks sub clock
// - main source bit 0 picks fast internal, 1 fast system clock
// - after reset cpu and peripherals run from fast internal clock
// - status bits 7 and 5 read-only; bit 7 shows cpu clock source
// - halt bits act per pin pair mode: port, oscillator, external
module system_clock_gating_select
  import clk_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // cpu power state
  input  wire logic        cpu_standby,
  // oscillator and clock pin controls
  output logic             main_osc_run,
  output logic             main_ext_clk_accept,
  output logic             sub_osc_run,
  output logic             sub_ext_clk_valid,
  output logic             fast_internal_osc_run,
  // clock routing
  output logic             main_clk_from_fast_system,
  output logic             cpu_clk_from_sub,
  output logic             sub_periph_clk_en,
  output logic             timer_rtc_clk_from_sub,
  output logic             timer_rtc_clk_from_lowspeed
);
  import clk_ctrl_pkg::*;

  reg_access_if acc ();
  gate_ctrl_if  gate ();

  // software-written state
  logic [7:0]    run_ctrl_r, run_ctrl_nxt;
  logic [7:0]    speed_r, speed_nxt;
  logic [7:0]    pin_mode_r, pin_mode_nxt;
  logic          cpu_src_sel_r, cpu_src_sel_nxt;
  logic          main_src_sel_r, main_src_sel_nxt;
  // switch state
  switch_state_t sw_state_r, sw_state_nxt;
  logic [2:0]    settle_cnt_r, settle_cnt_nxt;
  logic          cpu_stat_r, cpu_stat_nxt;
  logic          main_stat_r, main_stat_nxt;
  // registered pin controls
  logic          main_osc_run_r, main_osc_run_nxt;
  logic          main_ext_r, main_ext_nxt;
  logic          sub_osc_run_r, sub_osc_run_nxt;
  logic          sub_ext_r, sub_ext_nxt;
  logic          fast_int_run_r, fast_int_run_nxt;
  // decoded source availability
  pin_mode_t     main_mode, sub_mode;
  logic          fast_sys_avail, sub_avail, fast_int_avail;
  logic          target_avail, switch_wanted;
  logic [7:0]    syssel_rd;

  // bus slave
  axi_lite_port u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .regs    (acc.slave)
  );

  // subsystem clock gating
  sub_clock_gate u_gate (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ctl     (gate.gate)
  );

  // register writes, masked to the defined bits
  always_comb begin
    run_ctrl_nxt     = run_ctrl_r;
    speed_nxt        = speed_r;
    pin_mode_nxt     = pin_mode_r;
    cpu_src_sel_nxt  = cpu_src_sel_r;
    main_src_sel_nxt = main_src_sel_r;
    if (acc.wr_pulse) begin
      case (acc.wr_addr)
        RUN_CTRL_OFS: run_ctrl_nxt = acc.wr_data & RUN_CTRL_MASK;
        SPEED_OFS:    speed_nxt    = acc.wr_data & SPEED_MASK;
        PINMODE_OFS:  pin_mode_nxt = acc.wr_data & PINMODE_MASK;
        SYSSEL_OFS: begin
          // status bits 7 and 5 are not written
          cpu_src_sel_nxt  = acc.wr_data[SEL_CPU_SRC_BIT];
          main_src_sel_nxt = acc.wr_data[SEL_MAIN_SRC_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ctrl_r     <= RUN_CTRL_RST;
      speed_r        <= SPEED_RST;
      pin_mode_r     <= PINMODE_RST;
      cpu_src_sel_r  <= SRC_SEL_RST;
      main_src_sel_r <= SRC_SEL_RST;
    end else begin
      run_ctrl_r     <= run_ctrl_nxt;
      speed_r        <= speed_nxt;
      pin_mode_r     <= pin_mode_nxt;
      cpu_src_sel_r  <= cpu_src_sel_nxt;
      main_src_sel_r <= main_src_sel_nxt;
    end
  end

  // read path; unused bits come back zero
  assign syssel_rd = {cpu_stat_r, cpu_src_sel_r, main_stat_r,
                      main_src_sel_r, 4'h0};
  always_comb begin
    acc.rd_hit = reg_hit(acc.rd_addr);
    case (acc.rd_addr)
      RUN_CTRL_OFS: acc.rd_data = run_ctrl_r;
      SPEED_OFS:    acc.rd_data = speed_r;
      SYSSEL_OFS:   acc.rd_data = syssel_rd;
      PINMODE_OFS:  acc.rd_data = pin_mode_r;
      default:      acc.rd_data = 8'h00;
    endcase
  end

  // pin pair modes and which sources can really deliver a clock
  always_comb begin
    main_mode = pin_mode(pin_mode_r[PIN_EXT_MAIN_BIT],
                         pin_mode_r[PIN_MAIN_SEL_BIT]);
    sub_mode  = pin_mode(pin_mode_r[PIN_EXT_SUB_BIT],
                         pin_mode_r[PIN_SUB_SEL_BIT]);
    fast_sys_avail = (main_mode != PIN_PORT)
                     && !run_ctrl_r[RUN_MAIN_HALT_BIT];
    sub_avail      = (sub_mode != PIN_PORT)
                     && !run_ctrl_r[RUN_SUB_HALT_BIT];
    fast_int_avail = !run_ctrl_r[RUN_FAST_HALT_BIT];
  end

  // oscillator enables; a pin pair in port mode ignores its halt bit
  always_comb begin
    main_osc_run_nxt = (main_mode == PIN_OSC)
                       && !run_ctrl_r[RUN_MAIN_HALT_BIT];
    main_ext_nxt     = (main_mode == PIN_EXT)
                       && !run_ctrl_r[RUN_MAIN_HALT_BIT];
    sub_osc_run_nxt  = (sub_mode == PIN_OSC)
                       && !run_ctrl_r[RUN_SUB_HALT_BIT];
    sub_ext_nxt      = (sub_mode == PIN_EXT)
                       && !run_ctrl_r[RUN_SUB_HALT_BIT];
    fast_int_run_nxt = fast_int_avail;
  end

  // the selected sources must both be running before a switch lands
  always_comb begin
    switch_wanted = (cpu_src_sel_r != cpu_stat_r)
                    || (main_src_sel_r != main_stat_r);
    target_avail  = (main_src_sel_r ? fast_sys_avail : fast_int_avail)
                    && (!cpu_src_sel_r || sub_avail);
  end

  // clock source switch sequencer
  always_comb begin
    sw_state_nxt   = sw_state_r;
    settle_cnt_nxt = settle_cnt_r;
    cpu_stat_nxt   = cpu_stat_r;
    main_stat_nxt  = main_stat_r;
    case (sw_state_r)
      SW_STEADY: begin
        if (switch_wanted) begin
          sw_state_nxt = SW_WAIT;
        end
      end
      SW_WAIT: begin
        if (!switch_wanted) begin
          sw_state_nxt = SW_STEADY;
        end else if (target_avail) begin
          sw_state_nxt   = SW_SETTLE;
          settle_cnt_nxt = SETTLE_CYCLES - 3'h1;
        end
      end
      SW_SETTLE: begin
        if (!target_avail) begin
          sw_state_nxt = SW_WAIT;
        end else if (settle_cnt_r == 3'h0) begin
          cpu_stat_nxt  = cpu_src_sel_r;
          main_stat_nxt = main_src_sel_r;
          sw_state_nxt  = SW_STEADY;
        end else begin
          settle_cnt_nxt = settle_cnt_r - 3'h1;
        end
      end
      default: sw_state_nxt = SW_STEADY;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_state_r     <= SW_STEADY;
      settle_cnt_r   <= 3'h0;
      cpu_stat_r     <= SRC_SEL_RST;
      main_stat_r    <= SRC_SEL_RST;
      main_osc_run_r <= 1'b0;
      main_ext_r     <= 1'b0;
      sub_osc_run_r  <= 1'b0;
      sub_ext_r      <= 1'b0;
      fast_int_run_r <= 1'b1;
    end else begin
      sw_state_r     <= sw_state_nxt;
      settle_cnt_r   <= settle_cnt_nxt;
      cpu_stat_r     <= cpu_stat_nxt;
      main_stat_r    <= main_stat_nxt;
      main_osc_run_r <= main_osc_run_nxt;
      main_ext_r     <= main_ext_nxt;
      sub_osc_run_r  <= sub_osc_run_nxt;
      sub_ext_r      <= sub_ext_nxt;
      fast_int_run_r <= fast_int_run_nxt;
    end
  end

  // feed the gating block from registered state, standby straight from cpu_standby
  assign gate.cpu_on_sub     = cpu_stat_r;
  assign gate.standby        = cpu_standby;
  assign gate.gate_enable    = speed_r[SPD_GATE_BIT];
  assign gate.timer_lowspeed = speed_r[SPD_TIMER_SEL_BIT];

  // outputs, all from flip-flops
  assign main_osc_run                = main_osc_run_r;
  assign main_ext_clk_accept         = main_ext_r;
  assign sub_osc_run                 = sub_osc_run_r;
  assign sub_ext_clk_valid           = sub_ext_r;
  assign fast_internal_osc_run       = fast_int_run_r;
  assign main_clk_from_fast_system   = main_stat_r;
  assign cpu_clk_from_sub            = cpu_stat_r;
  assign sub_periph_clk_en           = gate.sub_periph_en;
  assign timer_rtc_clk_from_sub      = gate.timer_from_sub;
  assign timer_rtc_clk_from_lowspeed = gate.timer_from_lowspeed;

endmodule // system_clock_gating_select

// file: dv/system_clock_gating_select_asserts.sv
`timescale 1ns/1ns
module system_clock_gating_select_asserts (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // read channel
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // power state and clock outputs
  input wire logic        cpu_standby,
  input wire logic        main_osc_run,
  input wire logic        main_ext_clk_accept,
  input wire logic        sub_osc_run,
  input wire logic        sub_ext_clk_valid,
  input wire logic        fast_internal_osc_run,
  input wire logic        main_clk_from_fast_system,
  input wire logic        cpu_clk_from_sub,
  input wire logic        sub_periph_clk_en,
  input wire logic        timer_rtc_clk_from_sub,
  input wire logic        timer_rtc_clk_from_lowspeed
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // sources right after reset release
  AST_RESET_SRC: assert property (
    $rose(aresetn) |-> fast_internal_osc_run && !cpu_clk_from_sub &&
    !main_clk_from_fast_system)
    else $error("clock sources wrong after reset");
  // one pin pair cannot run oscillator and external clock at once
  AST_MAIN_PAIR: assert property (
    !(main_osc_run && main_ext_clk_accept))
    else $error("main pin pair in two modes");
  AST_SUB_PAIR: assert property (
    !(sub_osc_run && sub_ext_clk_valid))
    else $error("sub pin pair in two modes");
  AST_TIMER_SEL: assert property (
    timer_rtc_clk_from_sub != timer_rtc_clk_from_lowspeed)
    else $error("timer clock choice not one-hot");
  // gating only in standby on the sub clock
  AST_GATE_ON: assert property (
    !cpu_standby |=> sub_periph_clk_en)
    else $error("sub clock withheld outside standby");
  AST_GATE_OFF: assert property (
    !sub_periph_clk_en |-> $past(cpu_standby) && $past(cpu_clk_from_sub))
    else $error("sub clock withheld without cause");
  // a landed switch holds through settling
  AST_CPU_SETTLE: assert property (
    $changed(cpu_clk_from_sub) |=> $stable(cpu_clk_from_sub) [*3])
    else $error("cpu clock source toggled too fast");
  AST_MAIN_SETTLE: assert property (
    $changed(main_clk_from_fast_system) |=>
    $stable(main_clk_from_fast_system) [*3])
    else $error("main clock source toggled too fast");
  // read data upper bits and hold
  AST_RDATA_HIGH: assert property (
    rvalid |-> rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_RVALID_HOLD: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped or changed");
endmodule // system_clock_gating_select_asserts

bind system_clock_gating_select system_clock_gating_select_asserts
  u_system_clock_gating_select_asserts (
  .aclk(aclk), .aresetn(aresetn), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .cpu_standby(cpu_standby), .main_osc_run(main_osc_run),
  .main_ext_clk_accept(main_ext_clk_accept), .sub_osc_run(sub_osc_run),
  .sub_ext_clk_valid(sub_ext_clk_valid),
  .fast_internal_osc_run(fast_internal_osc_run),
  .main_clk_from_fast_system(main_clk_from_fast_system),
  .cpu_clk_from_sub(cpu_clk_from_sub),
  .sub_periph_clk_en(sub_periph_clk_en),
  .timer_rtc_clk_from_sub(timer_rtc_clk_from_sub),
  .timer_rtc_clk_from_lowspeed(timer_rtc_clk_from_lowspeed));

// file: dv/system_clock_gating_select_tb.sv
`timescale 1ns/1ns
module system_clock_gating_select_tb
  import clk_ctrl_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        cpu_standby, awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, pm;
  logic        main_osc_run, main_ext_clk_accept, sub_osc_run;
  logic        sub_ext_clk_valid, fast_internal_osc_run, cpu_clk_from_sub;
  logic        main_clk_from_fast_system, sub_periph_clk_en;
  logic        timer_rtc_clk_from_sub, timer_rtc_clk_from_lowspeed;
  logic        h, a, b, lag;
  logic [9:0]  outs;
  int          err_total, checks;

  // all clock outputs as one vector
  assign outs = {main_osc_run, main_ext_clk_accept, sub_osc_run,
                 sub_ext_clk_valid, fast_internal_osc_run,
                 main_clk_from_fast_system, cpu_clk_from_sub,
                 sub_periph_clk_en, timer_rtc_clk_from_sub,
                 timer_rtc_clk_from_lowspeed};

  system_clock_gating_select u_system_clock_gating_select (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cpu_standby(cpu_standby), .main_osc_run(main_osc_run),
    .main_ext_clk_accept(main_ext_clk_accept), .sub_osc_run(sub_osc_run),
    .sub_ext_clk_valid(sub_ext_clk_valid),
    .fast_internal_osc_run(fast_internal_osc_run),
    .main_clk_from_fast_system(main_clk_from_fast_system),
    .cpu_clk_from_sub(cpu_clk_from_sub),
    .sub_periph_clk_en(sub_periph_clk_en),
    .timer_rtc_clk_from_sub(timer_rtc_clk_from_sub),
    .timer_rtc_clk_from_lowspeed(timer_rtc_clk_from_lowspeed));

  // 25 MHz clock
  always #20 aclk = ~aclk;

  // compare tasks
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t data %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t resp %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t bit %b exp %b", $time, got, exp);
    end
  endtask

  // axi write, holds each channel until taken
  task automatic wr(input logic [31:0] ad, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!(bvalid === 1'b1 && bready));
    bready <= 1'b0;
    chk_resp(bresp, er);
  endtask

  // axi read; with lag set rready waits until rvalid shows
  task automatic rd(input logic [31:0] ad, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= !lag;
    do begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1 && !rready)
        rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready));
    rready <= 1'b0;
    chk_data(rdata, e);
    chk_resp(rresp, er);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic stby(input logic v);
    @(posedge aclk);
    cpu_standby <= v;
  endtask
  task automatic reset_chk();
    @(posedge aclk);
    #1;
    chk_data({22'h0, outs}, 32'h026);
  endtask

  task automatic finish_test();
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    finish_test();
  end

  // main sequence
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    wstrb = 4'hF;
    cpu_standby = 1'b0;
    lag = 1'b0;
    err_total = 0;
    checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    reset_chk();
    rd(RUN_CTRL_OFS, 32'hC0, RESP_OKAY);
    rd(SPEED_OFS, 32'h00, RESP_OKAY);
    rd(SYSSEL_OFS, 32'h00, RESP_OKAY);
    rd(PINMODE_OFS, 32'h00, RESP_OKAY);
    // fast oscillator halt and unused bits
    wr(RUN_CTRL_OFS, 32'hFF, 4'hF, RESP_OKAY);
    settle(2);
    chk_bit(fast_internal_osc_run, 1'b0);
    rd(RUN_CTRL_OFS, 32'hC1, RESP_OKAY);
    // every pin mode with halt bits clear and set
    for (int i = 0; i < 8; i++) begin
      pm = i[1:0];
      h = i[2];
      a = (pm == 2'b01) && !h;
      b = (pm == 2'b11) && !h;
      wr(PINMODE_OFS, {24'h0, pm, pm, 4'h0}, 4'hF, RESP_OKAY);
      wr(RUN_CTRL_OFS, {24'h0, h, h, 6'h0}, 4'hF, RESP_OKAY);
      settle(2);
      chk_data({22'h0, outs}, {22'h0, a, b, a, b, 6'h26});
    end
    // timer clock choice
    wr(SPEED_OFS, 32'hFF, 4'hF, RESP_OKAY);
    rd(SPEED_OFS, 32'h90, RESP_OKAY);
    chk_bit(timer_rtc_clk_from_lowspeed, 1'b1);
    chk_bit(timer_rtc_clk_from_sub, 1'b0);
    // standby on main clock leaves gate open
    wr(PINMODE_OFS, 32'h50, 4'hF, RESP_OKAY);
    wr(RUN_CTRL_OFS, 32'h40, 4'hF, RESP_OKAY);
    stby(1'b1);
    settle(3);
    chk_bit(sub_periph_clk_en, 1'b1);
    stby(1'b0);
    // main clock to fast system clock
    wr(SYSSEL_OFS, 32'h10, 4'hF, RESP_OKAY);
    settle(10);
    chk_bit(main_clk_from_fast_system, 1'b1);
    rd(SYSSEL_OFS, 32'h30, RESP_OKAY);
    // cpu to a halted sub clock must wait
    wr(SYSSEL_OFS, 32'h50, 4'hF, RESP_OKAY);
    settle(10);
    chk_bit(cpu_clk_from_sub, 1'b0);
    rd(SYSSEL_OFS, 32'h70, RESP_OKAY);
    wr(RUN_CTRL_OFS, 32'h00, 4'hF, RESP_OKAY);
    settle(10);
    chk_bit(cpu_clk_from_sub, 1'b1);
    rd(SYSSEL_OFS, 32'hF0, RESP_OKAY);
    // gating in standby on the sub clock
    stby(1'b1);
    settle(3);
    chk_bit(sub_periph_clk_en, 1'b0);
    stby(1'b0);
    settle(3);
    chk_bit(sub_periph_clk_en, 1'b1);
    wr(SPEED_OFS, 32'h10, 4'hF, RESP_OKAY);
    stby(1'b1);
    settle(3);
    chk_bit(sub_periph_clk_en, 1'b1);
    stby(1'b0);
    // status bits ignore writes, back to fast internal
    wr(SYSSEL_OFS, 32'hA0, 4'hF, RESP_OKAY);
    settle(12);
    rd(SYSSEL_OFS, 32'h00, RESP_OKAY);
    // refused accesses, reads from here on stall rready
    lag = 1'b1;
    wr(RUN_CTRL_OFS, 32'hFF, 4'h0, RESP_OKAY);
    rd(RUN_CTRL_OFS, 32'h00, RESP_OKAY);
    wr(32'h10, 32'hFF, 4'hF, RESP_DECERR);
    rd(32'h10, 32'h00, RESP_DECERR);
    // reset in mid-run
    wr(RUN_CTRL_OFS, 32'h01, 4'hF, RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    reset_chk();
    rd(RUN_CTRL_OFS, 32'hC0, RESP_OKAY);
    finish_test();
  end
endmodule // system_clock_gating_select_tb
